/* rtl/uqf_top.sv */
//------------------------------------------------------------------------------
// Purpose: second main configuration register, rx flow control, tx queue split
// Assumes: apb slave, zero wait states, inputs synchronous to pclk
// Notes:   address/clav/enable count field is not held here and reads zero
//------------------------------------------------------------------------------
`timescale 1ns/1ps
module uqf_top
  import uqf_pkg::*;
(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [UQF_ADDR_W-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  input  wire logic [3:0]            pstrb,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  rx_phy_mode,
  input  wire logic                  utopia_level2,
  input  wire logic [5:0]            phy_ports,
  input  wire logic                  rx_cell_store,
  input  wire logic                  rx_cell_take,
  input  wire logic                  rx_enb_req,
  output logic                       rx_clav,
  output logic                       rx_enb_n,
  output logic [6:0]                 queues_total,
  output logic [6:0]                 queues_used,
  output logic [7:0]                 cells_per_queue,
  output logic [2:0]                 queues_per_port,
  output logic [31:0]                port_served,
  output logic                       div_reserved,
  output logic                       upper_cfg_en
);

  // ---------------------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------------------
  logic [15:0] cfg_q;
  logic [15:0] cfg_d;
  logic [31:0] prdata_q;
  logic [2:0]  fill;
  logic        fifo_full;

  wire        setup_rd  = psel & ~penable & ~pwrite;
  wire        access    = psel & penable;
  wire        hit_cfg   = (paddr == UQF_CFG_ADDR);
  wire        hit_stat  = (paddr == UQF_STAT_ADDR);
  wire        mapped    = hit_cfg | hit_stat;
  wire        wr_cfg    = access & pwrite & hit_cfg;
  wire [15:0] lane_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}} & UQF_CFG_WMASK;

  // reserved bit 15 is stored as written; bits 3:0, 7, 14:11 read zero
  assign cfg_d = wr_cfg ? ((cfg_q & ~lane_mask) | (pwdata[15:0] & lane_mask)) : cfg_q;

  wire       full_sel  = cfg_q[UQF_SEL_BIT];
  wire       clav_ovr  = cfg_q[UQF_CLAV_OVR_BIT];
  wire       inhibit   = cfg_q[UQF_INHIBIT_BIT];
  wire [2:0] div_code  = cfg_q[UQF_DIV_MSB:UQF_DIV_LSB];
  wire       level2_atm = utopia_level2 & ~rx_phy_mode;

  logic [15:0] status;
  always_comb begin
    status = 16'h0000;
    status[UQF_ST_FILL_MSB:UQF_ST_FILL_LSB] = fill;
    status[UQF_ST_FULL_BIT] = fifo_full;
    status[UQF_ST_RSV_BIT]  = div_reserved;
    status[UQF_ST_USED_MSB:UQF_ST_USED_LSB] = queues_used;
    status[UQF_ST_UPPER_BIT] = upper_cfg_en;
  end

  wire [31:0] rd_word = hit_cfg  ? {16'h0000, cfg_q} :
                        hit_stat ? {16'h0000, status} : 32'h0000_0000;

  // read data captured in setup so it comes from a flop in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q    <= UQF_CFG_RESET;
      prdata_q <= 32'h0000_0000;
    end else begin
      cfg_q <= cfg_d;
      if (setup_rd) begin
        prdata_q <= rd_word;
      end
    end
  end

  assign prdata  = prdata_q;
  assign pready  = 1'b1;
  assign pslverr = access & ~mapped;

  // ---------------------------------------------------------------------------
  // receive flow control
  // ---------------------------------------------------------------------------
  uqf_cell_fill u_fill (
    .pclk       (pclk),
    .presetn    (presetn),
    .cell_store (rx_cell_store),
    .cell_take  (rx_cell_take),
    .fill_q     (fill),
    .full_q     (fifo_full)
  );

  assign rx_clav = rx_phy_mode & (clav_ovr | ~fifo_full);

  // no inhibit, enable follows request
  // in phy mode the enable pin belongs to the far side, so stay inactive
  assign rx_enb_n = ~(rx_enb_req & ~rx_phy_mode & ~(inhibit & fifo_full));

  // ---------------------------------------------------------------------------
  // transmit queue allocation
  // ---------------------------------------------------------------------------
  uqf_queue_alloc u_alloc (
    .pclk              (pclk),
    .presetn           (presetn),
    .full_sel          (full_sel),
    .div_code          (div_code),
    .level2_atm        (level2_atm),
    .phy_ports         (phy_ports),
    .queues_total_q    (queues_total),
    .queues_used_q     (queues_used),
    .cells_per_queue_q (cells_per_queue),
    .queues_per_port_q (queues_per_port),
    .port_served_q     (port_served),
    .div_reserved_q    (div_reserved),
    .upper_cfg_en_q    (upper_cfg_en)
  );

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_clav_override;
    rx_phy_mode && clav_ovr && fill == 3'h4 |-> rx_clav;
  endproperty
  a_clav_override: assert property (p_clav_override)
    else $error("clav dropped despite override");

  property p_clav_full;
    rx_phy_mode && !clav_ovr && fill == 3'h4 |-> !rx_clav;
  endproperty
  a_clav_full: assert property (p_clav_full)
    else $error("clav high while fifo full");

  property p_fill_full;
    fill == 3'h3 && rx_cell_store && !rx_cell_take |=> fifo_full && fill == 3'h4;
  endproperty
  a_fill_full: assert property (p_fill_full)
    else $error("fourth cell did not make fifo full");

  property p_enb_inhibit;
    !rx_phy_mode && inhibit && fill == 3'h4 |-> rx_enb_n;
  endproperty
  a_enb_inhibit: assert property (p_enb_inhibit)
    else $error("enable asserted into full fifo");

  property p_enb_free;
    !rx_phy_mode && !inhibit && rx_enb_req |-> !rx_enb_n;
  endproperty
  a_enb_free: assert property (p_enb_free)
    else $error("enable dropped without inhibit");

  property p_div_table;
    $past(div_code) == 3'h0 |-> queues_total == 7'h04 && cells_per_queue == 8'h20;
  endproperty
  a_div_table: assert property (p_div_table)
    else $error("code 000 split wrong");

  property p_legacy_64;
    $past(div_code) == 3'h4 && !$past(full_sel) |->
      queues_total == 7'h40 && queues_used == 7'h20;
  endproperty
  a_legacy_64: assert property (p_legacy_64)
    else $error("legacy 64 queue split wrong");

  property p_upper_off;
    !upper_cfg_en |-> port_served[31:16] == 16'h0000;
  endproperty
  a_upper_off: assert property (p_upper_off)
    else $error("upper port served in legacy mode");

  property p_full_32;
    $past(full_sel) && $past(level2_atm) && $past(phy_ports) == 6'h20 &&
      $past(div_code) == 3'h1 |-> port_served == 32'h0000_000f;
  endproperty
  a_full_32: assert property (p_full_32)
    else $error("eight queues at 32 ports wrong");

  property p_legacy_16;
    !$past(full_sel) && $past(level2_atm) && $past(phy_ports) == 6'h10 &&
      $past(div_code) == 3'h0 |-> port_served == 32'h0000_0003 && queues_per_port == 3'h2;
  endproperty
  a_legacy_16: assert property (p_legacy_16)
    else $error("four queues at 16 ports wrong");

  property p_reserved;
    $past(div_code) inside {3'h6, 3'h7} |-> div_reserved && queues_total == 7'h01;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved code not flagged");

  // ---------------------------------------------------------------------------
  // further allocation and flow checks
  // ---------------------------------------------------------------------------
  property p_div_8;
    $past(div_code) == 3'h1 |-> queues_total == 7'h08 && cells_per_queue == 8'h10;
  endproperty
  a_div_8: assert property (p_div_8)
    else $error("code 001 split wrong");

  property p_div_16;
    $past(div_code) == 3'h2 |-> queues_total == 7'h10 && cells_per_queue == 8'h08;
  endproperty
  a_div_16: assert property (p_div_16)
    else $error("code 010 split wrong");

  property p_div_32;
    $past(div_code) == 3'h3 |-> queues_total == 7'h20 && cells_per_queue == 8'h04;
  endproperty
  a_div_32: assert property (p_div_32)
    else $error("code 011 split wrong");

  property p_div_1;
    $past(div_code) == 3'h5 |-> queues_total == 7'h01 && cells_per_queue == UQF_BUF_CELLS;
  endproperty
  a_div_1: assert property (p_div_1)
    else $error("code 101 split wrong");

  property p_full_64;
    $past(div_code) == 3'h4 && $past(full_sel) |->
      queues_total == 7'h40 && queues_used == 7'h40;
  endproperty
  a_full_64: assert property (p_full_64)
    else $error("full mode 64 queue split wrong");

  property p_legacy_used;
    !$past(full_sel) && $past(div_code) != 3'h4 |-> queues_used == queues_total;
  endproperty
  a_legacy_used: assert property (p_legacy_used)
    else $error("legacy mode cut queues for another code");

  property p_two_qpp_full;
    $past(full_sel) && $past(level2_atm) && $past(phy_ports) == 6'h20 |->
      queues_per_port == 3'h2;
  endproperty
  a_two_qpp_full: assert property (p_two_qpp_full)
    else $error("32 ports did not get two queues each");

  property p_qpp_four;
    $past(level2_atm) && $past(phy_ports) < 6'h10 |-> queues_per_port == 3'h4;
  endproperty
  a_qpp_four: assert property (p_qpp_four)
    else $error("few ports did not get four queues each");

  property p_low_first;
    ((port_served + 32'h0000_0001) & port_served) == 32'h0000_0000;
  endproperty
  a_low_first: assert property (p_low_first)
    else $error("served ports not packed from port 0");

  property p_clav_atm;
    !rx_phy_mode |-> !rx_clav;
  endproperty
  a_clav_atm: assert property (p_clav_atm)
    else $error("clav driven in atm mode");

  property p_full_flag;
    fifo_full == (fill == 3'h4);
  endproperty
  a_full_flag: assert property (p_full_flag)
    else $error("full flag disagrees with cell count");

  property p_fill_drop;
    fill == 3'h4 && rx_cell_take && !rx_cell_store |=> !fifo_full && fill == 3'h3;
  endproperty
  a_fill_drop: assert property (p_fill_drop)
    else $error("take at full did not clear full");

  property p_upper_en;
    upper_cfg_en == $past(full_sel);
  endproperty
  a_upper_en: assert property (p_upper_en)
    else $error("upper settings enable does not follow select");

  c_fifo_full:   cover property (rx_cell_store ##1 fifo_full);
  c_override:    cover property (rx_phy_mode && clav_ovr && fifo_full);
  c_inhibit:     cover property (!rx_phy_mode && inhibit && fifo_full && rx_enb_req);
  c_legacy_64:   cover property (!full_sel && div_code == 3'h4 ##1 queues_used == 7'h20);
  c_legacy_16:   cover property (!full_sel && level2_atm && phy_ports == 6'h10
                                 ##1 queues_per_port == 3'h2);

endmodule

/* pkg/uqf_pkg.sv */
//------------------------------------------------------------------------------
// Purpose: constants for the utopia queue and flow configuration block
// Assumes: apb register port, one 25 MHz clock
// Notes:   register byte address is four times the register index
//------------------------------------------------------------------------------
package uqf_pkg;

  // ---------------------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------------------
  localparam int          UQF_ADDR_W     = 12;
  localparam logic [15:0] UQF_CFG_IDX    = 16'h0112;
  localparam logic [15:0] UQF_STAT_IDX   = 16'h0113;
  localparam logic [11:0] UQF_CFG_ADDR   = 12'(UQF_CFG_IDX * 16'h0004);
  localparam logic [11:0] UQF_STAT_ADDR  = 12'(UQF_STAT_IDX * 16'h0004);
  localparam logic [15:0] UQF_CFG_RESET  = 16'h0000;
  localparam logic [15:0] UQF_CFG_WMASK  = 16'h8770;

  // ---------------------------------------------------------------------------
  // config field positions
  // ---------------------------------------------------------------------------
  localparam int UQF_SEL_BIT     = 4;
  localparam int UQF_CLAV_OVR_BIT = 5;
  localparam int UQF_INHIBIT_BIT = 6;
  localparam int UQF_DIV_LSB     = 8;
  localparam int UQF_DIV_MSB     = 10;

  // ---------------------------------------------------------------------------
  // status field positions
  // ---------------------------------------------------------------------------
  localparam int UQF_ST_FILL_LSB = 0;
  localparam int UQF_ST_FILL_MSB = 2;
  localparam int UQF_ST_FULL_BIT = 3;
  localparam int UQF_ST_RSV_BIT  = 4;
  localparam int UQF_ST_USED_LSB = 8;
  localparam int UQF_ST_USED_MSB = 14;
  localparam int UQF_ST_UPPER_BIT = 15;

  // ---------------------------------------------------------------------------
  // queue division codes and sizes
  // ---------------------------------------------------------------------------
  localparam logic [2:0] UQF_DIV_4   = 3'h0;
  localparam logic [2:0] UQF_DIV_8   = 3'h1;
  localparam logic [2:0] UQF_DIV_16  = 3'h2;
  localparam logic [2:0] UQF_DIV_32  = 3'h3;
  localparam logic [2:0] UQF_DIV_64  = 3'h4;
  localparam logic [2:0] UQF_DIV_1   = 3'h5;
  localparam logic [7:0] UQF_BUF_CELLS     = 8'h80;
  localparam logic [6:0] UQF_LEGACY_USED   = 7'h20;
  localparam logic [5:0] UQF_PORTS_FULL    = 6'h20;
  localparam logic [5:0] UQF_PORTS_LEGACY  = 6'h10;
  localparam logic [2:0] UQF_FIFO_FULL_CELLS = 3'h4;

endpackage

/* rtl/uqf_cell_fill.sv */
//------------------------------------------------------------------------------
// Purpose: count receive fifo cells not yet taken by internal processing
// Assumes: store and take are one-cycle pulses
// Notes:   count saturates; a store beyond full is an overrun and not counted
//------------------------------------------------------------------------------
`timescale 1ns/1ps
module uqf_cell_fill
  import uqf_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       cell_store,
  input  wire logic       cell_take,
  output logic [2:0]      fill_q,
  output logic            full_q
);

  logic [2:0] fill_d;
  wire        inc = cell_store & ~cell_take & (fill_q != UQF_FIFO_FULL_CELLS);
  wire        dec = cell_take & ~cell_store & (fill_q != 3'h0);

  always_comb begin
    fill_d = fill_q;
    if (inc) begin
      fill_d = fill_q + 3'h1;
    end else if (dec) begin
      fill_d = fill_q - 3'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fill_q <= 3'h0;
      full_q <= 1'b0;
    end else begin
      fill_q <= fill_d;
      full_q <= (fill_d == UQF_FIFO_FULL_CELLS);
    end
  end

endmodule

/* rtl/uqf_queue_alloc.sv */
//------------------------------------------------------------------------------
// Purpose: derive transmit queue split and per-port queue allocation
// Assumes: configuration changes are rare; outputs lag inputs by one cycle
// Notes:   reserved division codes fall back to a single queue
//------------------------------------------------------------------------------
`timescale 1ns/1ps
module uqf_queue_alloc
  import uqf_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       full_sel,
  input  wire logic [2:0] div_code,
  input  wire logic       level2_atm,
  input  wire logic [5:0] phy_ports,
  output logic [6:0]      queues_total_q,
  output logic [6:0]      queues_used_q,
  output logic [7:0]      cells_per_queue_q,
  output logic [2:0]      queues_per_port_q,
  output logic [31:0]     port_served_q,
  output logic            div_reserved_q,
  output logic            upper_cfg_en_q
);

  logic [6:0] total;
  logic [7:0] cells;
  logic       rsv;

  // reserved codes act as one queue
  always_comb begin
    rsv = 1'b0;
    case (div_code)
      UQF_DIV_4:  begin total = 7'h04; cells = 8'h20; end
      UQF_DIV_8:  begin total = 7'h08; cells = 8'h10; end
      UQF_DIV_16: begin total = 7'h10; cells = 8'h08; end
      UQF_DIV_32: begin total = 7'h20; cells = 8'h04; end
      UQF_DIV_64: begin total = 7'h40; cells = 8'h02; end
      UQF_DIV_1:  begin total = 7'h01; cells = UQF_BUF_CELLS; end
      default:    begin total = 7'h01; cells = UQF_BUF_CELLS; rsv = 1'b1; end
    endcase
  end

  // legacy 64-queue split uses only 32
  wire [6:0] used     = (!full_sel && div_code == UQF_DIV_64) ? UQF_LEGACY_USED : total;
  wire [5:0] port_cap = full_sel ? UQF_PORTS_FULL : UQF_PORTS_LEGACY;
  wire [5:0] eff_port = (phy_ports > port_cap) ? port_cap : phy_ports;
  // two queues per port at the port limit
  // same rule with the legacy limit
  wire       two_qpp  = level2_atm && (phy_ports == port_cap);
  wire [2:0] qpp      = two_qpp ? 3'h2 : 3'h4;
  wire [6:0] served   = two_qpp ? (used >> 1) : (used >> 2);
  logic [31:0] served_mask;

  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++) begin : g_port
      localparam logic [6:0] PIDX = 7'(gi);
      // upper ports ignored in legacy mode
      assign served_mask[gi] = level2_atm ? ((PIDX < served) && (PIDX[5:0] < eff_port))
                                          : (gi == 0);
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      queues_total_q    <= 7'h04;
      queues_used_q     <= 7'h04;
      cells_per_queue_q <= 8'h20;
      queues_per_port_q <= 3'h4;
      port_served_q     <= 32'h0000_0000;
      div_reserved_q    <= 1'b0;
      upper_cfg_en_q    <= 1'b0;
    end else begin
      queues_total_q    <= total;
      queues_used_q     <= used;
      cells_per_queue_q <= cells;
      queues_per_port_q <= qpp;
      port_served_q     <= served_mask;
      div_reserved_q    <= rsv;
      upper_cfg_en_q    <= full_sel;
    end
  end

endmodule

/* tb/uqf_far_end.sv */
//------------------------------------------------------------------------------
// Purpose: far side utopia device offering cells to the rx fifo
// Assumes: it only offers a cell in the cycle after the block signals room
// Notes:   slow pacing offers on every other cycle only
//------------------------------------------------------------------------------
`timescale 1ns/1ps
module uqf_far_end (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic offer,
  input  wire logic slow,
  input  wire logic rx_phy_mode,
  input  wire logic rx_clav,
  input  wire logic rx_enb_n,
  output logic      cell_store
);
  logic pace_q;
  logic room;

  // room is judged on the previous cycle, so one overrun store can slip in
  assign room = rx_phy_mode ? rx_clav : ~rx_enb_n;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pace_q     <= 1'b0;
      cell_store <= 1'b0;
    end else begin
      pace_q     <= ~pace_q;
      cell_store <= offer & room & (~slow | pace_q);
    end
  end
endmodule

/* tb/tb.sv */
//------------------------------------------------------------------------------
// Purpose: self-checking bench for the queue and flow configuration block
// Assumes: zero wait state apb slave, 40 ns clock
// Notes:   expectations are queued by the driver and checked on falling edges
//------------------------------------------------------------------------------
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module tb;
  import uqf_pkg::*;
  typedef struct packed { logic [3:0] sel; logic [32:0] val; } uqf_chk_t;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, port_served;
  logic [3:0]  pstrb;
  logic        rx_phy_mode, utopia_level2, rx_cell_store, rx_cell_take, rx_enb_req;
  logic        rx_clav, rx_enb_n, div_reserved, upper_cfg_en, probe, offer, slow, sel, lv;
  logic [5:0]  phy_ports;
  logic [6:0]  queues_total, queues_used;
  logic [7:0]  cells_per_queue;
  logic [2:0]  queues_per_port, code;
  uqf_chk_t    exp_q[$];
  uqf_chk_t    mon_e;
  int          n_mismatch, total_checks, cyc, ports, tot, used, lim, qpp, n;

  uqf_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_phy_mode(rx_phy_mode),
    .utopia_level2(utopia_level2), .phy_ports(phy_ports), .rx_cell_store(rx_cell_store),
    .rx_cell_take(rx_cell_take), .rx_enb_req(rx_enb_req), .rx_clav(rx_clav),
    .rx_enb_n(rx_enb_n), .queues_total(queues_total), .queues_used(queues_used),
    .cells_per_queue(cells_per_queue), .queues_per_port(queues_per_port),
    .port_served(port_served), .div_reserved(div_reserved), .upper_cfg_en(upper_cfg_en));
  uqf_far_end i_far (.pclk(pclk), .presetn(presetn), .offer(offer), .slow(slow),
    .rx_phy_mode(rx_phy_mode), .rx_clav(rx_clav), .rx_enb_n(rx_enb_n),
    .cell_store(rx_cell_store));

  // ---------------------------------------------------------------------------
  // bench plumbing
  // ---------------------------------------------------------------------------
  function automatic logic [32:0] out_of(input logic [3:0] s);
    case (s)
      4'h1: out_of = {32'h0, rx_clav};
      4'h2: out_of = {32'h0, rx_enb_n};
      4'h3: out_of = {26'h0, queues_total};
      4'h4: out_of = {26'h0, queues_used};
      4'h5: out_of = {25'h0, cells_per_queue};
      4'h6: out_of = {30'h0, queues_per_port};
      4'h7: out_of = {1'b0, port_served};
      4'h8: out_of = {32'h0, div_reserved};
      4'h9: out_of = {32'h0, upper_cfg_en};
      default: out_of = {pslverr, prdata};
    endcase
  endfunction

  task give_verdict;
    if (n_mismatch == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // falling edge sampling keeps clear of the launch edge
  always @(negedge pclk) begin
    if ((psel && penable && !pwrite) || probe) begin
      mon_e = exp_q.pop_front();
      `CHK(out_of(mon_e.sel), mon_e.val)
    end
  end

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic [32:0] ev);
    if (!w) exp_q.push_back('{4'h0, ev});
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hf, 33'h0);
  endtask

  task automatic rd(input logic [11:0] a, input logic [32:0] ev);
    apb(1'b0, a, 32'h0, 4'h0, ev);
  endtask

  task automatic see(input logic [3:0] s, input logic [32:0] v);
    exp_q.push_back('{s, v});
    @(posedge pclk);
    probe <= 1'b1;
    @(posedge pclk);
    probe <= 1'b0;
  endtask

  // fill the rx fifo to saturation, check the flow output, then drain
  task automatic rx_run(input logic ph, input logic [1:0] ctl, input logic full_lvl);
    logic [3:0] s;
    s = ph ? 4'h1 : 4'h2;
    wr(UQF_CFG_ADDR, 32'h8510 | (32'(ctl) << 5));
    @(posedge pclk);
    rx_phy_mode <= ph; rx_enb_req <= 1'b1; offer <= 1'b1; slow <= 1'($urandom % 2);
    repeat (12) @(posedge pclk);
    offer <= 1'b0;
    repeat (2) @(posedge pclk);
    see(s, 33'(full_lvl));
    rd(UQF_STAT_ADDR, 33'h810c);
    @(posedge pclk);
    rx_cell_take <= 1'b1;
    @(posedge pclk);
    rx_cell_take <= 1'b0;
    see(s, 33'(ph));
    @(posedge pclk);
    rx_cell_take <= 1'b1;
    repeat (3) @(posedge pclk);
    rx_cell_take <= 1'b0;
  endtask

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // ---------------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------------
  initial begin
    presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; pstrb = 0;
    rx_phy_mode = 0; utopia_level2 = 0; phy_ports = 0; rx_cell_take = 0;
    rx_enb_req = 0; probe = 0; offer = 0; slow = 0;
    void'($urandom(32'h48eb39df));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(UQF_CFG_ADDR, 33'h0);
    rd(UQF_STAT_ADDR, 33'h0400);
    wr(UQF_CFG_ADDR, 32'hffffffff);
    rd(UQF_CFG_ADDR, {17'h0, UQF_CFG_WMASK});
    apb(1'b1, UQF_CFG_ADDR, 32'h0, 4'h1, 33'h0);
    rd(UQF_CFG_ADDR, 33'h8700);
    wr(UQF_STAT_ADDR, 32'hffff);
    rd(UQF_STAT_ADDR, 33'h0110);
    rd(12'h000, 33'h1_0000_0000);
    for (int i = 0; i < 24; i++) begin
      sel = (i < 8) ? 1'(i != 4 && i != 0) : 1'($urandom % 2);
      code = (i < 8) ? 3'(i) : 3'($urandom % 8);
      ports = (i == 1) ? 32 : (i == 4 || i == 0) ? 16 : 1 + int'($urandom % 32);
      lv = (i < 8) ? 1'b1 : 1'($urandom % 2);
      @(posedge pclk);
      phy_ports <= 6'(ports);
      utopia_level2 <= lv;
      wr(UQF_CFG_ADDR, 32'h8000 | (32'(sel) << 4) | (32'(code) << 8));
      repeat (2) @(posedge pclk);
      tot = (code < 5) ? (4 << code) : 1;
      used = (!sel && code == 3'h4) ? 32 : tot;
      lim = sel ? 32 : 16;
      qpp = (ports == lim) ? 2 : 4;
      n = used / qpp;
      if (n > ports) n = ports;
      if (n > lim) n = lim;
      see(4'h3, 33'(tot));
      see(4'h4, 33'(used));
      see(4'h5, 33'(128 / tot));
      see(4'h8, 33'(code > 3'h5));
      see(4'h9, 33'(sel));
      see(4'h7, lv ? (33'h1 << n) - 33'h1 : 33'h1);
      if (lv) see(4'h6, 33'(qpp));
    end
    rx_run(1'b1, 2'b00, 1'b0);
    rx_run(1'b1, 2'b01, 1'b1);
    rx_run(1'b0, 2'b10, 1'b1);
    rx_run(1'b0, 2'b00, 1'b0);
    repeat (2) @(posedge pclk);
    give_verdict();
  end
endmodule
